// ---- lra_drive_chk.sv ----
/*
  Port checker of the resonance drive controller, bound to its top module.
  Assumes one clock and the asynchronous active-low reset of the design.
*/
`timescale 1ns/1ps
module lra_drive_chk #(
  parameter int EN_CYC = 30
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // actuator feedback
  input wire logic zeroCrossIn,
  input wire logic bemfValidIn,
  // drive outputs
  input wire logic driveActive,
  input wire logic drivePolarity,
  input wire logic [7:0] driveAmplitude,
  input wire logic overdriveEnable,
  input wire logic brakeEnable,
  input wire logic openLoopActive,
  input wire logic lraSynced
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [15:0] rstCnt_r; // cycles since reset, saturating
  logic [15:0] rstCnt_nxt;
  // next count stops at full scale so it never wraps
  always_comb begin
    rstCnt_nxt = (rstCnt_r == 16'hffff) ? rstCnt_r : rstCnt_r + 16'h1;
  end
  // count register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstCnt_r <= 16'h0;
    end else begin
      rstCnt_r <= rstCnt_nxt;
    end
  end
  // a crossing with valid back-emf while tracking or fallback drive runs
  sequence validCross;
    $changed(zeroCrossIn) && bemfValidIn && driveActive && overdriveEnable
      ##1 (bemfValidIn && driveActive)[*3];
  endsequence
  // enabled open loop holds until drive stops
  property olHold;
    (openLoopActive && !overdriveEnable && driveActive) |=>
      (!driveActive || (openLoopActive && !overdriveEnable && !lraSynced));
  endproperty
  AST_SYNC_LOCK: assert property (validCross |-> ##[0:4] lraSynced)
    else $error("no lock after valid crossing");
  AST_POL_FLIP: assert property (validCross |-> ##[0:4] $changed(drivePolarity))
    else $error("polarity not flipped on crossing");
  AST_NO_RESYNC: assert property (olHold)
    else $error("open loop left while driving");
  AST_SYNC_EXCL: assert property (lraSynced |-> driveActive && !openLoopActive)
    else $error("synced flag outside tracking");
  AST_IDLE_QUIET: assert property (!driveActive |-> !openLoopActive && !lraSynced)
    else $error("status set while idle");
  AST_STOP_QUIET: assert property ($fell(driveActive) |-> driveAmplitude == 8'h00 && !overdriveEnable)
    else $error("drive left on after stop");
  AST_BRAKE_OD: assert property (brakeEnable == overdriveEnable)
    else $error("brake and overdrive disagree");
  AST_FALLBACK: assert property ((driveActive && overdriveEnable && !bemfValidIn)[*6] |-> openLoopActive)
    else $error("no fallback on invalid back-emf");
  AST_EN_LAT: assert property (driveActive |-> rstCnt_r >= EN_CYC)
    else $error("drive before enable latency");
endmodule : lra_drive_chk

bind lra_resonance_drive_ctrl lra_drive_chk #(.EN_CYC(EN_CYC)) u_lra_drive_chk (
  .clk(clk),
  .reset_n(reset_n),
  .zeroCrossIn(zeroCrossIn),
  .bemfValidIn(bemfValidIn),
  .driveActive(driveActive),
  .drivePolarity(drivePolarity),
  .driveAmplitude(driveAmplitude),
  .overdriveEnable(overdriveEnable),
  .brakeEnable(brakeEnable),
  .openLoopActive(openLoopActive),
  .lraSynced(lraSynced)
);

// ---- lra_drive_consts.svh ----
/*
  Constants of the resonance drive controller: register offsets, field
  positions, reset values and timing figures.
  Assumes a 5 ns system clock; times are kept in picoseconds.
*/
`ifndef LRA_DRIVE_CONSTS_SVH
`define LRA_DRIVE_CONSTS_SVH

// register offsets
`define LRA_OFS_MODE 8'h01
`define LRA_OFS_RTP 8'h02
`define LRA_OFS_GO 8'h0c
`define LRA_OFS_FBCTL 8'h1a
`define LRA_OFS_DRVTIME 8'h1b
`define LRA_OFS_OLCTL 8'h1f
`define LRA_OFS_OLPER 8'h20
`define LRA_OFS_PERIOD 8'h22

// field positions
`define LRA_TYPE_BIT 7
`define LRA_OLEN_BIT 5
`define LRA_OLCNT_LSB 2
`define LRA_ZC_LSB 0

// reset values
`define LRA_MODE_RST 8'h00
`define LRA_RTP_RST 8'h00
`define LRA_FBCTL_RST 8'h00
`define LRA_DRVTIME_RST 8'h13
`define LRA_OLCTL_RST 8'h00
`define LRA_OLPER_RST 8'h33
`define LRA_PERIOD_RST 8'h00

// fewest unsynchronised cycles, added to the limit field
`define LRA_OLCNT_BASE 3'h3

// timing, picoseconds
`define LRA_CLK_PS 5000
`define LRA_T_GO_PS 700000000
`define LRA_T_EN_PS 1170000000
`define LRA_T_OLUNIT_PS 98490000
`define LRA_T_DRVSTEP_PS 100000000
`define LRA_T_ZCSTEP_PS 100000000

// cycle counts derived from the times above
`define LRA_GO_CYC ((`LRA_T_GO_PS + `LRA_CLK_PS - 1) / `LRA_CLK_PS)
`define LRA_EN_CYC ((`LRA_T_EN_PS + `LRA_CLK_PS - 1) / `LRA_CLK_PS)
`define LRA_OLUNIT_CYC (`LRA_T_OLUNIT_PS / `LRA_CLK_PS)
`define LRA_DRVSTEP_CYC (`LRA_T_DRVSTEP_PS / `LRA_CLK_PS)
`define LRA_ZCSTEP_CYC (`LRA_T_ZCSTEP_PS / `LRA_CLK_PS)

`endif

// ---- lra_drive_pkg.sv ----
/*
  Types of the resonance drive controller: interface modes and the
  states of the drive and serial machines.
  Assumes the constants header is included by the design file.
*/
package lra_drive_pkg;
  // interface mode field
  typedef enum logic [2:0] {
    LRA_MODE_INT = 3'h0,
    LRA_MODE_EXT = 3'h1,
    LRA_MODE_PWM = 3'h3,
    LRA_MODE_RTP = 3'h5
  } lra_mode_t;
  // drive machine
  typedef enum {LRA_IDLE, LRA_START, LRA_TRACK, LRA_FALLBACK, LRA_OPENLOOP} lra_drv_state_t;
  // serial slave machine
  typedef enum {I2C_IDLE, I2C_ADDR, I2C_ACKA, I2C_PTR, I2C_ACKP, I2C_WDATA, I2C_ACKW,
    I2C_RDATA, I2C_RACK} lra_i2c_state_t;
endpackage : lra_drive_pkg

// ---- lra_host_actuator_model.sv ----
/*
  Far side of the controller: serial host with open-drain data line and
  an actuator whose comparator toggles every crossHalf cycles.
  Assumes the bench calls wr and rd one at a time.
*/
`timescale 1ns/1ps
module lra_host_actuator_model #(
  parameter logic [6:0] ADDR = 7'h2c, // arbitrary bus address
  parameter int LO = 260, // scl low, 1.3 us
  parameter int HI = 240 // scl high; period 2.5 us keeps 400 kHz
) (
  // clock
  input wire logic clk,
  // serial bus
  output logic scl,
  output logic sda,
  input wire logic devPull,
  // actuator
  input wire logic [15:0] crossHalf,
  output logic zeroCross
);
  logic hostPull; // host pulls sda low
  logic [15:0] crossCnt; // cycles since last crossing
  int nackCnt; // bytes left without acknowledge
  assign sda = !(hostPull || devPull); // pull-up when nobody pulls
  initial begin
    scl = 1'b1;
    hostPull = 1'b0;
    zeroCross = 1'b0;
    crossCnt = 16'h0;
    nackCnt = 0;
  end
  // crossings stop while crossHalf is zero; comparator then holds
  always @(posedge clk) begin
    if (crossHalf == 16'h0) begin
      crossCnt <= 16'h0;
    end else if (crossCnt >= crossHalf - 16'h1) begin
      crossCnt <= 16'h0;
      zeroCross <= !zeroCross;
    end else begin
      crossCnt <= crossCnt + 16'h1;
    end
  end
  // one bit; data changes mid-low, line sampled mid-high
  task automatic bitx(input logic b, output logic r);
    repeat (LO / 2) @(posedge clk);
    hostPull <= !b;
    repeat (LO - LO / 2) @(posedge clk);
    scl <= 1'b1;
    repeat (HI / 2) @(posedge clk);
    r = sda;
    repeat (HI - HI / 2) @(posedge clk);
    scl <= 1'b0;
  endtask : bitx
  // start or repeated start
  task automatic startCond;
    hostPull <= 1'b0;
    repeat (LO / 2) @(posedge clk);
    scl <= 1'b1;
    repeat (HI / 2) @(posedge clk);
    hostPull <= 1'b1;
    repeat (HI / 2) @(posedge clk);
    scl <= 1'b0;
  endtask : startCond
  // stop, then bus free time
  task automatic stopCond;
    repeat (LO / 2) @(posedge clk);
    hostPull <= 1'b1;
    repeat (LO / 2) @(posedge clk);
    scl <= 1'b1;
    repeat (HI / 2) @(posedge clk);
    hostPull <= 1'b0;
    repeat (LO) @(posedge clk);
  endtask : stopCond
  // eight bits msb first, line levels returned
  task automatic xfer(input logic [7:0] b, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      bitx(b[i], q[i]);
    end
  endtask : xfer
  // byte out, device acknowledge expected
  task automatic put(input logic [7:0] b);
    logic [7:0] q;
    logic a;
    xfer(b, q);
    bitx(1'b1, a);
    if (a) begin
      nackCnt++;
    end
  endtask : put
  // write n bytes of d from the top, pointer first
  task automatic wr(input logic [7:0] ptr, input logic [15:0] d, input int n);
    startCond();
    put({ADDR, 1'b0});
    put(ptr);
    for (int k = 0; k < n; k++) begin
      put(k == 0 ? d[15:8] : d[7:0]);
    end
    stopCond();
  endtask : wr
  // two-byte read from ptr; last byte refused to end it
  task automatic rd(input logic [7:0] ptr, output logic [15:0] d);
    logic a;
    startCond();
    put({ADDR, 1'b0});
    put(ptr);
    startCond();
    put({ADDR, 1'b1});
    xfer(8'hff, d[15:8]);
    bitx(1'b0, a);
    xfer(8'hff, d[7:0]);
    bitx(1'b1, a);
    stopCond();
  endtask : rd
endmodule : lra_host_actuator_model

// ---- lra_resonance_drive_ctrl.sv ----
/*
  Resonance drive controller: I2C register slave, actuator type select,
  back-EMF resonance tracker, open-loop fallback and start-up latency.
  Assumes scl/sda, trigger and comparator inputs are asynchronous pins,
  reset_n comes from the device enable, sda is open drain outside.
*/
// What this block does
// R01: type bit picks eccentric or resonant drive
// R02: lock at first crossing, re-track every cycle
// R03: tracker needs no calibration at all
// R04: resonance period readable, updated live
// R05: invalid back-EMF drops to default-rate open loop while the enable bit is clear
// R06: valid back-EMF returns tracker to control
// R07: fallback half period is drive minus zero-cross
// R08: enable bit gives open loop without resync
// R09: open loop after limit consecutive sync failures
// R10: open-loop period is field times unit time
// R11: enabled open loop drops overdrive and braking
// R12: drive starts 0.7 ms after go or trigger
// R13: pwm/analog drive starts 1.17 ms after enable
// R14: effects start by go bit or trigger edge
// R15: real-time mode drives host amplitude directly
// R16: host clocks serial bus at most 400 kHz
// R17: failure count clears on sync or new start
`timescale 1ns/1ps
`include "lra_drive_consts.svh"

module lra_resonance_drive_ctrl #(
  parameter logic [6:0] DEV_ADDR = 7'h2c, // arbitrary bus address
  parameter int GO_CYC = `LRA_GO_CYC,
  parameter int EN_CYC = `LRA_EN_CYC,
  parameter int OLUNIT_CYC = `LRA_OLUNIT_CYC,
  parameter int DRVSTEP_CYC = `LRA_DRVSTEP_CYC,
  parameter int ZCSTEP_CYC = `LRA_ZCSTEP_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // serial register bus
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // hardware trigger pin
  input wire logic pwmTriggerInput,
  // actuator feedback comparators
  input wire logic zeroCrossIn,
  input wire logic bemfValidIn,
  // drive outputs
  output logic driveActive,
  output logic drivePolarity,
  output logic [7:0] driveAmplitude,
  output logic overdriveEnable,
  output logic brakeEnable,
  output logic openLoopActive,
  output logic lraSynced
);
  import lra_drive_pkg::*;

  localparam logic [23:0] GO_C = 24'(GO_CYC);
  localparam logic [23:0] EN_C = 24'(EN_CYC);
  localparam logic [23:0] UNIT_C = 24'(OLUNIT_CYC);
  localparam logic [23:0] DSTEP_C = 24'(DRVSTEP_CYC);
  localparam logic [23:0] ZSTEP_C = 24'(ZCSTEP_CYC);

  // input synchronisers: stage 1 feeds stage 2 only
  logic [4:0] syncA_r; // scl, sda, trig, zc, valid
  logic [4:0] syncB_r;
  logic [3:0] prev_r; // delayed copies of scl, sda, trig, zc

  // synchronise all pins, then keep one delayed copy for edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA_r <= 5'h1b;
      syncB_r <= 5'h1b;
      prev_r <= 4'hd;
    end else begin
      syncA_r <= {sclIn, sdaIn, pwmTriggerInput, zeroCrossIn, bemfValidIn};
      syncB_r <= syncA_r;
      prev_r <= syncB_r[4:1];
    end
  end

  logic sclS, sdaS, trigS, zcS, validS;
  assign sclS = syncB_r[4];
  assign sdaS = syncB_r[3];
  assign trigS = syncB_r[2];
  assign zcS = syncB_r[1];
  assign validS = syncB_r[0];

  logic busStart, busStop, sclRise, sclFall, trigEdge, zcEdge;
  assign busStart = sclS && prev_r[3] && prev_r[2] && !sdaS;
  assign busStop = sclS && prev_r[3] && !prev_r[2] && sdaS;
  assign sclRise = sclS && !prev_r[3];
  assign sclFall = !sclS && prev_r[3];
  assign trigEdge = trigS && !prev_r[1]; // rising edge only
  assign zcEdge = zcS != prev_r[0]; // every comparator flip is a crossing

  // register file
  logic [7:0] mode_r, mode_nxt; // interface mode
  logic [7:0] rtp_r, rtp_nxt; // real-time amplitude
  logic go_r, go_nxt; // go bit
  logic [7:0] fbCtl_r, fbCtl_nxt; // actuator feedback control
  logic [7:0] drvTime_r, drvTime_nxt; // drive time setting
  logic [7:0] olCtl_r, olCtl_nxt; // open-loop control
  logic [6:0] olPer_r, olPer_nxt; // open-loop period field
  logic [7:0] period_r, period_nxt; // measured resonance period

  // serial slave state
  lra_i2c_state_t iSt_r, iSt_nxt;
  logic [3:0] bit_r, bit_nxt; // bits seen in this byte
  logic [7:0] sh_r, sh_nxt; // shift register
  logic [7:0] ptr_r, ptr_nxt; // register pointer, auto-incremented
  logic rw_r, rw_nxt; // 1 = read transfer
  logic oe_r, oe_nxt; // pull sda low
  logic wrEn; // one-cycle register write
  logic [7:0] rdByte; // register selected by the pointer

  // read mux; unmapped offsets read zero
  always_comb begin
    case (ptr_r)
      `LRA_OFS_MODE: rdByte = mode_r;
      `LRA_OFS_RTP: rdByte = rtp_r;
      `LRA_OFS_GO: rdByte = {7'h00, go_r};
      `LRA_OFS_FBCTL: rdByte = fbCtl_r;
      `LRA_OFS_DRVTIME: rdByte = drvTime_r;
      `LRA_OFS_OLCTL: rdByte = olCtl_r;
      `LRA_OFS_OLPER: rdByte = {1'b0, olPer_r};
      `LRA_OFS_PERIOD: rdByte = period_r; // [R04]
      default: rdByte = 8'h00;
    endcase
  end

  // serial slave: sample on scl rise, change sda on scl fall
  always_comb begin
    iSt_nxt = iSt_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    rw_nxt = rw_r;
    oe_nxt = oe_r;
    wrEn = 1'b0;
    if (busStop) begin
      iSt_nxt = I2C_IDLE;
      oe_nxt = 1'b0;
    end else if (busStart) begin
      iSt_nxt = I2C_ADDR; // also a repeated start; pointer kept
      bit_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else if (sclRise) begin
      case (iSt_r)
        I2C_ADDR, I2C_PTR, I2C_WDATA: begin
          sh_nxt = {sh_r[6:0], sdaS};
          bit_nxt = bit_r + 4'h1;
        end
        I2C_RDATA: bit_nxt = bit_r + 4'h1;
        I2C_RACK: begin
          if (sdaS) begin
            iSt_nxt = I2C_IDLE; // master ends the read
          end else begin
            ptr_nxt = ptr_r + 8'h01;
          end
        end
        default: ;
      endcase
    end else if (sclFall) begin
      case (iSt_r)
        I2C_ADDR: begin
          if (bit_r == 4'h8 && sh_r[7:1] == DEV_ADDR) begin
            rw_nxt = sh_r[0];
            oe_nxt = 1'b1;
            iSt_nxt = I2C_ACKA;
          end else if (bit_r == 4'h8) begin
            iSt_nxt = I2C_IDLE; // another device is addressed
          end
        end
        I2C_ACKA: begin
          bit_nxt = 4'h0;
          if (rw_r) begin
            sh_nxt = rdByte;
            oe_nxt = !rdByte[7];
            iSt_nxt = I2C_RDATA;
          end else begin
            oe_nxt = 1'b0;
            iSt_nxt = I2C_PTR;
          end
        end
        I2C_PTR: begin
          if (bit_r == 4'h8) begin
            ptr_nxt = sh_r;
            oe_nxt = 1'b1;
            iSt_nxt = I2C_ACKP;
          end
        end
        I2C_ACKP, I2C_ACKW: begin
          if (iSt_r == I2C_ACKW) begin
            ptr_nxt = ptr_r + 8'h01;
          end
          oe_nxt = 1'b0;
          bit_nxt = 4'h0;
          iSt_nxt = I2C_WDATA;
        end
        I2C_WDATA: begin
          if (bit_r == 4'h8) begin
            wrEn = 1'b1;
            oe_nxt = 1'b1;
            iSt_nxt = I2C_ACKW;
          end
        end
        I2C_RDATA: begin
          if (bit_r == 4'h8) begin
            oe_nxt = 1'b0; // let the master acknowledge
            iSt_nxt = I2C_RACK;
          end else begin
            sh_nxt = {sh_r[6:0], 1'b0};
            oe_nxt = !sh_r[6];
          end
        end
        I2C_RACK: begin
          sh_nxt = rdByte;
          oe_nxt = !rdByte[7];
          bit_nxt = 4'h0;
          iSt_nxt = I2C_RDATA;
        end
        default: ;
      endcase
    end
  end

  // serial slave registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      iSt_r <= I2C_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      iSt_r <= iSt_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      rw_r <= rw_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign sdaOut = 1'b0; // open drain: only ever pulls low
  assign sdaOe = oe_r;
  // drive state
  lra_drv_state_t st_r, st_nxt;
  logic [23:0] cnt_r, cnt_nxt; // half-cycle timer or latency counter
  logic [23:0] unit_r, unit_nxt; // prescaler for the period unit
  logic [7:0] ticks_r, ticks_nxt; // period units since last crossing
  logic [2:0] fail_r, fail_nxt; // consecutive unsynchronised cycles
  logic [23:0] en_r, en_nxt; // time since enable
  logic pol_r, pol_nxt;
  logic sync_r, sync_nxt;

  // derived settings
  logic isLra, olEn, play, enReady;
  logic [2:0] failLim;
  logic [23:0] fbHalf, olHalf, driveT, zcT;
  assign isLra = fbCtl_r[`LRA_TYPE_BIT]; // [R01]
  assign olEn = olCtl_r[`LRA_OLEN_BIT];
  assign failLim = {1'b0, olCtl_r[`LRA_OLCNT_LSB +: 2]} + `LRA_OLCNT_BASE;
  assign driveT = (24'(drvTime_r[4:0]) + 24'h1) * DSTEP_C;
  assign zcT = (24'(olCtl_r[`LRA_ZC_LSB +: 2]) + 24'h1) * ZSTEP_C;
  assign fbHalf = (driveT > zcT) ? driveT - zcT : DSTEP_C; // [R07]
  assign olHalf = 24'((32'(olPer_r) * 32'(UNIT_C)) >> 1); // [R10]
  assign enReady = en_r >= EN_C;
  // pwm/analog waits out the enable latency; others need go or rtp
  assign play = (mode_r[2:0] == LRA_MODE_RTP) ||
    (mode_r[2:0] == LRA_MODE_PWM && enReady) || // [R13]
    ((mode_r[2:0] == LRA_MODE_INT || mode_r[2:0] == LRA_MODE_EXT) && go_r); // [R14]

  // register writes and the drive machine; hardware sets win
  always_comb begin
    mode_nxt = mode_r;
    rtp_nxt = rtp_r;
    go_nxt = go_r;
    fbCtl_nxt = fbCtl_r;
    drvTime_nxt = drvTime_r;
    olCtl_nxt = olCtl_r;
    olPer_nxt = olPer_r;
    period_nxt = period_r;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    unit_nxt = unit_r;
    ticks_nxt = ticks_r;
    fail_nxt = fail_r;
    pol_nxt = pol_r;
    sync_nxt = sync_r;
    en_nxt = enReady ? en_r : en_r + 24'h1;
    if (wrEn) begin
      case (ptr_r)
        `LRA_OFS_MODE: mode_nxt = sh_r;
        `LRA_OFS_RTP: rtp_nxt = sh_r;
        `LRA_OFS_GO: go_nxt = sh_r[0];
        `LRA_OFS_FBCTL: fbCtl_nxt = sh_r;
        `LRA_OFS_DRVTIME: drvTime_nxt = sh_r;
        `LRA_OFS_OLCTL: olCtl_nxt = sh_r;
        `LRA_OFS_OLPER: olPer_nxt = sh_r[6:0];
        default: ; // read-only or unmapped: ignored
      endcase
    end
    if (trigEdge && mode_r[2:0] == LRA_MODE_EXT) begin
      go_nxt = 1'b1; // [R14]
    end
    // period unit prescaler, counts in every state
    unit_nxt = (unit_r >= UNIT_C - 24'h1) ? 24'h0 : unit_r + 24'h1;
    if (unit_r >= UNIT_C - 24'h1 && ticks_r != 8'hff) begin
      ticks_nxt = ticks_r + 8'h1;
    end
    cnt_nxt = cnt_r + 24'h1;
    case (st_r)
      LRA_IDLE: begin
        cnt_nxt = 24'h0;
        sync_nxt = 1'b0;
        if (play) begin
          fail_nxt = 3'h0; // [R17]
          // pwm mode already waited after enable
          st_nxt = (mode_r[2:0] == LRA_MODE_PWM) ? LRA_TRACK : LRA_START;
        end
      end
      LRA_START: begin
        if (cnt_r >= GO_C - 24'h1) begin // [R12]
          cnt_nxt = 24'h0;
          ticks_nxt = 8'h0;
          st_nxt = LRA_TRACK;
        end
      end
      LRA_TRACK: begin
        // the tracker runs straight from back-EMF, no calibration [R03]
        if (!isLra) begin
          pol_nxt = 1'b0; // eccentric mass: one direction [R01]
        end else if (zcEdge && validS) begin
          // commutate at every crossing: locks after half a cycle [R02]
          pol_nxt = !pol_r;
          cnt_nxt = 24'h0;
          fail_nxt = 3'h0; // [R17]
          sync_nxt = 1'b1;
          period_nxt = ticks_r[7] ? 8'hff : {ticks_r[6:0], 1'b0}; // [R04]
          ticks_nxt = 8'h0;
          unit_nxt = 24'h1; // the crossing edge is the first cycle of the new unit
        end else if (!validS && !olEn) begin
          st_nxt = LRA_FALLBACK; // [R05]
          cnt_nxt = 24'h0;
          sync_nxt = 1'b0;
        end else if (cnt_r >= {fbHalf[22:0], 1'b0}) begin
          // a full fallback cycle passed without a crossing
          pol_nxt = !pol_r;
          cnt_nxt = 24'h0;
          sync_nxt = 1'b0;
          if (!olEn) begin
            st_nxt = LRA_FALLBACK; // [R05]
          end else if (fail_r + 3'h1 >= failLim) begin
            st_nxt = LRA_OPENLOOP; // [R09]
          end else begin
            fail_nxt = fail_r + 3'h1; // [R09]
          end
        end
      end
      LRA_FALLBACK: begin
        if (zcEdge && validS) begin
          st_nxt = LRA_TRACK; // [R06]
          pol_nxt = !pol_r;
          cnt_nxt = 24'h0;
          ticks_nxt = 8'h0;
          fail_nxt = 3'h0;
          sync_nxt = 1'b1;
        end else if (cnt_r >= fbHalf - 24'h1) begin
          pol_nxt = !pol_r; // default-rate drive [R07]
          cnt_nxt = 24'h0;
        end
      end
      LRA_OPENLOOP: begin
        // crossings are ignored here: no resynchronisation [R08]
        if (cnt_r >= olHalf - 24'h1) begin
          pol_nxt = !pol_r; // [R10]
          cnt_nxt = 24'h0;
        end
      end
      default: st_nxt = LRA_IDLE;
    endcase
    if (!play) begin
      st_nxt = LRA_IDLE; // stop wins over any state
      sync_nxt = 1'b0; // no sync flag lingers into idle [R04]
    end
  end

  // register file and drive machine registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= `LRA_MODE_RST;
      rtp_r <= `LRA_RTP_RST;
      go_r <= 1'b0;
      fbCtl_r <= `LRA_FBCTL_RST;
      drvTime_r <= `LRA_DRVTIME_RST;
      olCtl_r <= `LRA_OLCTL_RST;
      olPer_r <= 7'(`LRA_OLPER_RST);
      period_r <= `LRA_PERIOD_RST;
      st_r <= LRA_IDLE;
      cnt_r <= 24'h0;
      unit_r <= 24'h0;
      ticks_r <= 8'h0;
      fail_r <= 3'h0;
      pol_r <= 1'b0;
      sync_r <= 1'b0;
      en_r <= 24'h0;
    end else begin
      mode_r <= mode_nxt;
      rtp_r <= rtp_nxt;
      go_r <= go_nxt;
      fbCtl_r <= fbCtl_nxt;
      drvTime_r <= drvTime_nxt;
      olCtl_r <= olCtl_nxt;
      olPer_r <= olPer_nxt;
      period_r <= period_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      unit_r <= unit_nxt;
      ticks_r <= ticks_nxt;
      fail_r <= fail_nxt;
      pol_r <= pol_nxt;
      sync_r <= sync_nxt;
      en_r <= en_nxt;
    end
  end

  logic running;
  assign running = st_r == LRA_TRACK || st_r == LRA_FALLBACK || st_r == LRA_OPENLOOP;

  // outputs straight from state
  assign driveActive = running;
  assign drivePolarity = pol_r;
  // host amplitude bypasses the effect engine in real-time mode
  assign driveAmplitude = !running ? 8'h00 :
    (mode_r[2:0] == LRA_MODE_RTP) ? rtp_r : 8'hff; // [R15]
  assign overdriveEnable = running && st_r != LRA_OPENLOOP; // [R11]
  assign brakeEnable = running && st_r != LRA_OPENLOOP; // [R11]
  assign openLoopActive = st_r == LRA_OPENLOOP || st_r == LRA_FALLBACK;
  assign lraSynced = sync_r;
endmodule : lra_resonance_drive_ctrl

// ---- lra_resonance_drive_ctrl_bench.sv ----
/*
  Self-checking bench of the resonance drive controller with shortened
  counts: go 20, enable 30, open-loop unit 8, drive step 10, zero-cross 4.
  Assumes the host and actuator model of this folder.
*/
`timescale 1ns/1ps
module lra_resonance_drive_ctrl_bench;
  logic clk; // 200 MHz
  logic reset_n;
  logic bemfValid; // back-emf valid level
  logic trig; // trigger pin
  logic [15:0] crossHalf; // actuator half period, 0 stops it
  wire sclW;
  wire sdaW;
  wire zc;
  logic sdaOut, sdaOe, driveActive, drivePolarity;
  logic overdriveEnable, brakeEnable, openLoopActive, lraSynced;
  logic [7:0] amp;
  int n_fail, comparisons;
  lra_resonance_drive_ctrl #(.GO_CYC(20), .EN_CYC(30), .OLUNIT_CYC(8), .DRVSTEP_CYC(10),
    .ZCSTEP_CYC(4)) u_lra_resonance_drive_ctrl (.clk(clk), .reset_n(reset_n), .sclIn(sclW),
    .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe), .pwmTriggerInput(trig), .zeroCrossIn(zc),
    .bemfValidIn(bemfValid), .driveActive(driveActive), .drivePolarity(drivePolarity),
    .driveAmplitude(amp), .overdriveEnable(overdriveEnable), .brakeEnable(brakeEnable),
    .openLoopActive(openLoopActive), .lraSynced(lraSynced));
  lra_host_actuator_model u_lra_host_actuator_model (.clk(clk), .scl(sclW), .sda(sdaW),
    .devPull(sdaOe), .crossHalf(crossHalf), .zeroCross(zc));
  always #2.5 clk = ~clk;
  // settled sampling point after an edge
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // bounded wait for a level
  task automatic waitSig(ref logic s, input logic v, output int n);
    n = 0;
    while (s !== v && n < 4000) begin
      tick();
      n++;
    end
  endtask : waitSig
  // cycles until the next polarity flip
  task automatic gap(output int n);
    logic p;
    p = drivePolarity;
    n = 0;
    while (drivePolarity === p && n < 3000) begin
      tick();
      n++;
    end
  endtask : gap
  task automatic t_track;
    int n;
    logic [15:0] d;
    u_lra_host_actuator_model.wr(8'h1a, 16'h8000, 1); // resonant type
    u_lra_host_actuator_model.wr(8'h0c, 16'h0100, 1); // go
    waitSig(driveActive, 1'b1, n);
    @(posedge clk) crossHalf <= 16'd40;
    repeat (200) tick();
    check("synced", lraSynced, 1);
    gap(n);
    gap(n);
    check("track gap", n, 40);
    u_lra_host_actuator_model.rd(8'h21, d);
    check("unmapped", d[15:8], 0);
    check("period", d[7:0], 8'h0a);
  endtask : t_track
  task automatic t_fallback;
    int n;
    @(posedge clk) begin
      bemfValid <= 1'b0;
      crossHalf <= 16'd0;
    end
    waitSig(openLoopActive, 1'b1, n);
    check("fallback", openLoopActive, 1);
    check("fb overdrive", overdriveEnable, 1);
    gap(n);
    gap(n);
    check("fb gap", n, 196);
    @(posedge clk) begin
      bemfValid <= 1'b1;
      crossHalf <= 16'd40;
    end
    waitSig(lraSynced, 1'b1, n);
    check("resync", openLoopActive, 0);
  endtask : t_fallback
  task automatic t_openloop;
    int n, n1, n2;
    u_lra_host_actuator_model.wr(8'h1f, 16'h2400, 1); // enable, limit 4
    @(posedge clk) crossHalf <= 16'd0;
    repeat (1300) tick();
    check("early ol", openLoopActive, 0);
    @(posedge clk) crossHalf <= 16'd40;
    repeat (300) tick();
    @(posedge clk) crossHalf <= 16'd0;
    waitSig(openLoopActive, 1'b1, n);
    check("ol delay", n >= 1480 && n <= 1620, 1);
    check("ol overdrive", overdriveEnable, 0);
    check("ol brake", brakeEnable, 0);
    gap(n);
    gap(n1);
    gap(n2);
    check("ol cycle", n1 + n2, 408);
    @(posedge clk) crossHalf <= 16'd40;
    repeat (400) tick();
    check("no resync", openLoopActive, 1);
    check("no sync", lraSynced, 0);
  endtask : t_openloop
  task automatic t_trigger;
    int n;
    u_lra_host_actuator_model.wr(8'h0c, 16'h0000, 1); // go cleared
    repeat (5) tick();
    check("stopped", driveActive, 0);
    u_lra_host_actuator_model.wr(8'h01, 16'h0100, 1); // trigger mode
    @(posedge clk) trig <= 1'b1;
    waitSig(driveActive, 1'b1, n);
    check("trigger latency", n >= 20 && n <= 26, 1);
    check("full amplitude", amp, 8'hff);
    @(posedge clk) trig <= 1'b0;
  endtask : t_trigger
  task automatic t_rtp;
    u_lra_host_actuator_model.wr(8'h01, 16'h055a, 2); // real-time mode and amplitude
    repeat (10) tick();
    check("rtp amp", amp, 8'h5a);
    check("rtp active", driveActive, 1);
  endtask : t_rtp
  task automatic stop_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  // main sequence
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    bemfValid = 1'b1;
    trig = 1'b0;
    crossHalf = 16'd0;
    n_fail = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    t_track();
    t_fallback();
    t_openloop();
    t_trigger();
    t_rtp();
    check("sda out", sdaOut, 0);
    check("acks", u_lra_host_actuator_model.nackCnt, 0);
    stop_test();
  end
  // watchdog, well past the expected run
  initial begin
    repeat (160000) @(posedge clk);
    n_fail++;
    $display("CHECK FAILED watchdog expected done seen hang");
    stop_test();
  end
endmodule : lra_resonance_drive_ctrl_bench
